// ==== rtl/pcg_gpio_bank.v ====
// Five-pin bank configured by decoded command packets, with PWM outputs,
// 32 Hz sampling and edge tracking. Assumes framing and CRC are checked upstream,
// and that saved boot state arrives on the boot ports when I_BOOT_LOAD pulses.
//
// Function
// - Index 0 to 4 valid, others reserved
// - Two bytes set value; three add mode
// - Accepted configure answers type 0x62, empty
// - 0 low, 1-99 PWM, 100 high
// - Mode byte 0-15: three drive, one function
// - Modes 000, 001, 010 decoded
// - Modes 011 and 100 decoded
// - Modes 101, 111 decoded; 110 reserved
// - Function clear gives default function
// - Sample every pin at 32 Hz
// - Latch rising and falling edges between queries
// - Sampling itself debounces short changes
// - Pull-up with switch reads open 1
// - Saved configuration restored at power-up
// - Factory defaults suit ATX and sensor bus
// - Query returns level, edges; clears edges
// - Query returns duty and mode byte
`timescale 1ns/1ps
`include "pcg_map.vh"
module pcg_gpio_bank
#(
	parameter NUM_PINS = `PCG_NUM_PINS,
	parameter PWM_STEP_CYC = `PCG_PWM_STEP_CYC,
	parameter SAMPLE_CYC = `PCG_SAMPLE_CYC
)
(
	// Clock and reset.
	input wire I_SYS_CLK,
	input wire I_RESET_N,
	// Decoded command: one-cycle strobe with type, length and payload.
	input wire I_CMD_VALID,
	input wire [7:0] I_CMD_TYPE,
	input wire [1:0] I_CMD_LEN,
	input wire [7:0] I_CMD_D0,
	input wire [7:0] I_CMD_D1,
	input wire [7:0] I_CMD_D2,
	// Reply: one-cycle strobe.
	output reg O_RSP_VALID,
	output reg [7:0] O_RSP_TYPE,
	output reg [2:0] O_RSP_LEN,
	output reg [7:0] O_RSP_D0,
	output reg [7:0] O_RSP_D1,
	output reg [7:0] O_RSP_D2,
	output reg [7:0] O_RSP_D3,
	output reg O_CMD_REJECT,
	// Saved boot state, flattened per pin (duty 8 bits, mode 4 bits).
	input wire I_BOOT_LOAD,
	input wire [8*NUM_PINS-1:0] I_BOOT_DUTY,
	input wire [4*NUM_PINS-1:0] I_BOOT_MODE,
	// Current configuration for saving.
	output reg [8*NUM_PINS-1:0] O_CFG_DUTY,
	output reg [4*NUM_PINS-1:0] O_CFG_MODE,
	// Default-function signals (ATX, one_wire_sensor_bus).
	input wire [NUM_PINS-1:0] I_DEF_OUT,
	input wire [NUM_PINS-1:0] I_DEF_OE,
	output reg [NUM_PINS-1:0] O_SAMPLED,
	// Pads.
	input wire [NUM_PINS-1:0] I_PIN,
	output wire [NUM_PINS-1:0] O_PIN,
	output wire [NUM_PINS-1:0] O_PIN_OE,
	output wire [NUM_PINS-1:0] O_PIN_SLOW,
	output wire [NUM_PINS-1:0] O_PIN_PU,
	output wire [NUM_PINS-1:0] O_PIN_PD
);
	// ****************************************
	// Configuration storage and command decode
	// ****************************************
	localparam [4*`PCG_NUM_PINS-1:0] RST_MODES = {`PCG_RST_MODE4, `PCG_RST_MODE3,
		`PCG_RST_MODE2, `PCG_RST_MODE1, `PCG_RST_MODE0};
	localparam [31:0] PWM_W = PWM_STEP_CYC;
	localparam [31:0] SMP_W = SAMPLE_CYC;

	reg [7:0] duty [0:NUM_PINS-1];
	reg [3:0] mode [0:NUM_PINS-1];
	reg [NUM_PINS-1:0] sync1;
	reg [NUM_PINS-1:0] sync2;
	reg [NUM_PINS-1:0] rise_flag;
	reg [NUM_PINS-1:0] fall_flag;
	reg [31:0] pwm_div;
	reg [6:0] pwm_phase;
	reg [31:0] smp_div;
	reg smp_tick;

	// A configure command is taken only when index, value, mode byte and
	// length are all in range. Anything else pulses the reject strobe and
	// leaves every pin untouched, so a corrupted packet cannot disturb the
	// shared power and sensor pins.
	wire is_cfg = I_CMD_VALID && (I_CMD_TYPE == `PCG_CMD_CONFIG);
	wire is_qry = I_CMD_VALID && (I_CMD_TYPE == `PCG_CMD_QUERY);
	wire idx_ok = (I_CMD_D0 < NUM_PINS);
	wire val_ok = (I_CMD_D1 <= `PCG_DUTY_HIGH);
	wire mode_ok = (I_CMD_LEN != 2'd3) || (I_CMD_D2 <= `PCG_MODE_MAX);
	wire len_ok = (I_CMD_LEN == 2'd2) || (I_CMD_LEN == 2'd3);
	wire cfg_ok = is_cfg && idx_ok && val_ok && mode_ok && len_ok;
	wire qry_ok = is_qry && idx_ok && (I_CMD_LEN == 2'd1);
	wire [2:0] idx = I_CMD_D0[2:0];

	genvar g;
	generate
		for (g = 0; g < NUM_PINS; g = g + 1)
		begin : g_pin
			wire [7:0] d = duty[g];
			wire [3:0] m = mode[g];
			reg pwm_level;
			wire level;

			// Configuration register of this pin.
			always @(posedge I_SYS_CLK or negedge I_RESET_N)
			begin
				if (!I_RESET_N)
				begin
					duty[g] <= `PCG_RST_DUTY;
					mode[g] <= RST_MODES[4*g +: 4];
				end
				else if (I_BOOT_LOAD)
				begin
					duty[g] <= I_BOOT_DUTY[8*g +: 8];
					mode[g] <= I_BOOT_MODE[4*g +: 4];
				end
				else if (cfg_ok && (idx == g))
				begin
					duty[g] <= I_CMD_D1;
					if (I_CMD_LEN == 2'd3)
						mode[g] <= I_CMD_D2[3:0];
				end
			end

			// PWM compare: duty percent of the 100-step period is high.
			// Duty 0 never passes the compare and duty 100 always does, which gives
			// the constant low and high levels without a separate path.
			always @(posedge I_SYS_CLK or negedge I_RESET_N)
			begin
				if (!I_RESET_N)
					pwm_level <= 1'b0;
				else
					pwm_level <= ({1'b0, pwm_phase} < d);
			end

			assign level = m[`PCG_FUNC_BIT] ? pwm_level : I_DEF_OUT[g];

			pcg_pin_drive u_drive
			(
				.i_clk(I_SYS_CLK),
				.i_reset_n(I_RESET_N),
				.i_level(level),
				.i_mode(m[`PCG_FUNC_BIT] ? m[2:0] : (I_DEF_OE[g] ? `PCG_DM_FAST_PP : m[2:0])),
				.o_out(O_PIN[g]),
				.o_oe(O_PIN_OE[g]),
				.o_slow(O_PIN_SLOW[g]),
				.o_pull_up(O_PIN_PU[g]),
				.o_pull_down(O_PIN_PD[g])
			);

			// Sampled level and edge flags.
			// Each new sample is compared with the previous one, so a pulse that
			// starts and ends between two ticks is never seen. A tick and a query in
			// the same cycle keep the new edge: the set wins over the clear.
			always @(posedge I_SYS_CLK or negedge I_RESET_N)
			begin
				if (!I_RESET_N)
				begin
					O_SAMPLED[g] <= 1'b0;
					rise_flag[g] <= 1'b0;
					fall_flag[g] <= 1'b0;
				end
				else
				begin
					if (smp_tick)
						O_SAMPLED[g] <= sync2[g];
					if (smp_tick && sync2[g] && !O_SAMPLED[g])
						rise_flag[g] <= 1'b1;
					else if (qry_ok && (idx == g))
						rise_flag[g] <= 1'b0;
					if (smp_tick && !sync2[g] && O_SAMPLED[g])
						fall_flag[g] <= 1'b1;
					else if (qry_ok && (idx == g))
						fall_flag[g] <= 1'b0;
				end
			end

			// Flattened copy for saving.
			always @(posedge I_SYS_CLK or negedge I_RESET_N)
			begin
				if (!I_RESET_N)
				begin
					O_CFG_DUTY[8*g +: 8] <= 8'h00;
					O_CFG_MODE[4*g +: 4] <= 4'h0;
				end
				else
				begin
					O_CFG_DUTY[8*g +: 8] <= d;
					O_CFG_MODE[4*g +: 4] <= m;
				end
			end
		end
	endgenerate

	// ****************************************
	// Timebases and input synchroniser
	// ****************************************

	// PWM step divider, 100 phases per 10 ms; sample divider at 32 Hz.
	// Both dividers run freely from reset, so sampling is not tied to the
	// moment at which the host sends its queries.
	always @(posedge I_SYS_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			pwm_div <= 32'h0000_0000;
			pwm_phase <= 7'h00;
			smp_div <= 32'h0000_0000;
			smp_tick <= 1'b0;
		end
		else
		begin
			if (pwm_div >= PWM_W - 32'h1)
			begin
				pwm_div <= 32'h0000_0000;
				pwm_phase <= (pwm_phase == 7'h63) ? 7'h00 : pwm_phase + 7'h01;
			end
			else
				pwm_div <= pwm_div + 32'h1;
			smp_tick <= (smp_div >= SMP_W - 32'h1);
			smp_div <= (smp_div >= SMP_W - 32'h1) ? 32'h0000_0000 : smp_div + 32'h1;
		end
	end

	// Two-stage synchroniser for the pad inputs.
	// Only the second stage is read by the sampler; the first may go
	// metastable when a pad changes close to the clock edge.
	always @(posedge I_SYS_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			sync1 <= {NUM_PINS{1'b0}};
			sync2 <= {NUM_PINS{1'b0}};
		end
		else
		begin
			sync1 <= I_PIN;
			sync2 <= sync1;
		end
	end

	// ****************************************
	// Replies
	// ****************************************

	// One reply per accepted command, the cycle after the strobe.
	// Payload bytes beyond the reply length keep old values; the host reads only the length given.
	always @(posedge I_SYS_CLK or negedge I_RESET_N)
	begin
		if (!I_RESET_N)
		begin
			O_RSP_VALID <= 1'b0;
			O_RSP_TYPE <= 8'h00;
			O_RSP_LEN <= 3'h0;
			O_RSP_D0 <= 8'h00;
			O_RSP_D1 <= 8'h00;
			O_RSP_D2 <= 8'h00;
			O_RSP_D3 <= 8'h00;
			O_CMD_REJECT <= 1'b0;
		end
		else
		begin
			O_RSP_VALID <= cfg_ok || qry_ok;
			O_CMD_REJECT <= (is_cfg && !cfg_ok) || (is_qry && !qry_ok);
			if (cfg_ok)
			begin
				O_RSP_TYPE <= `PCG_REPLY_CONFIG;
				O_RSP_LEN <= 3'h0;
			end
			else if (qry_ok)
			begin
				O_RSP_TYPE <= `PCG_REPLY_QUERY;
				O_RSP_LEN <= 3'h4;
				O_RSP_D0 <= I_CMD_D0;
				O_RSP_D1 <= {5'h00, rise_flag[idx], fall_flag[idx], O_SAMPLED[idx]};
				O_RSP_D2 <= duty[idx];
				O_RSP_D3 <= {4'h0, mode[idx]};
			end
		end
	end
endmodule // pcg_gpio_bank

// ==== rtl/pcg_map.vh ====
// Constants for the packet configured pin bank: command codes, field positions,
// reset values and timing counts. Assumes a 200 MHz system clock.
`ifndef PCG_MAP_VH
`define PCG_MAP_VH
// Command and reply type codes.
`define PCG_CMD_CONFIG 8'h22
`define PCG_REPLY_CONFIG 8'h62
`define PCG_CMD_QUERY 8'h23
`define PCG_REPLY_QUERY 8'h63
// Limits and field positions.
`define PCG_NUM_PINS 5
`define PCG_DUTY_HIGH 8'h64
`define PCG_MODE_MAX 8'h0F
`define PCG_FUNC_BIT 3
// Drive mode codes.
`define PCG_DM_FAST_PD 3'h0
`define PCG_DM_FAST_PP 3'h1
`define PCG_DM_HIZ 3'h2
`define PCG_DM_PU_FAST 3'h3
`define PCG_DM_SLOW_HI 3'h4
`define PCG_DM_SLOW_PP 3'h5
`define PCG_DM_RSVD 3'h6
`define PCG_DM_SLOW_LO 3'h7
// Factory defaults: all five pins on default functions; pin 1 pull-up drive, pins 0 and 2 to 4 Hi-Z.
`define PCG_RST_DUTY 8'h00
`define PCG_RST_MODE0 4'h2
`define PCG_RST_MODE1 4'h3
`define PCG_RST_MODE2 4'h2
`define PCG_RST_MODE3 4'h2
`define PCG_RST_MODE4 4'h2
// Timing: clock rate, PWM step (100 Hz over 100 steps), sample period (32 Hz).
`define PCG_CLK_HZ 200000000
`define PCG_PWM_HZ 100
`define PCG_SAMPLE_HZ 32
`define PCG_PWM_STEP_CYC (`PCG_CLK_HZ / (`PCG_PWM_HZ * 100))
`define PCG_SAMPLE_CYC (`PCG_CLK_HZ / `PCG_SAMPLE_HZ)
`endif

// ==== rtl/pcg_pin_drive.v ====
// One pin's driver: maps drive mode and level onto pin output, enable and pulls.
// Assumes level comes from the bank's PWM or default-function input, on the same clock.
`timescale 1ns/1ps
`include "pcg_map.vh"
module pcg_pin_drive
(
	// Clock and reset.
	input wire i_clk,
	input wire i_reset_n,
	// Level and mode.
	input wire i_level,
	input wire [2:0] i_mode,
	// Pad controls.
	output reg o_out,
	output reg o_oe,
	output reg o_slow,
	output reg o_pull_up,
	output reg o_pull_down
);
	reg next_out;
	reg next_oe;
	reg next_slow;
	reg next_pu;
	reg next_pd;

	// Decode of the eight drive modes; reserved code floats the pin.
	always @*
	begin
		next_out = i_level;
		next_oe = 1'b0;
		next_slow = 1'b0;
		next_pu = 1'b0;
		next_pd = 1'b0;
		case (i_mode)
			`PCG_DM_FAST_PD:
			begin
				next_oe = i_level;
				next_pd = ~i_level;
			end
			`PCG_DM_FAST_PP: next_oe = 1'b1;
			`PCG_DM_HIZ: next_oe = 1'b0;
			`PCG_DM_PU_FAST:
			begin
				next_oe = ~i_level;
				next_pu = i_level;
			end
			`PCG_DM_SLOW_HI:
			begin
				next_oe = i_level;
				next_slow = 1'b1;
			end
			`PCG_DM_SLOW_PP:
			begin
				next_oe = 1'b1;
				next_slow = 1'b1;
			end
			`PCG_DM_SLOW_LO:
			begin
				next_oe = ~i_level;
				next_slow = 1'b1;
			end
			default: next_oe = 1'b0;
		endcase
	end

	// Pad controls are registered so the pins never glitch.
	always @(posedge i_clk or negedge i_reset_n)
	begin
		if (!i_reset_n)
		begin
			o_out <= 1'b0;
			o_oe <= 1'b0;
			o_slow <= 1'b0;
			o_pull_up <= 1'b0;
			o_pull_down <= 1'b0;
		end
		else
		begin
			o_out <= next_out;
			o_oe <= next_oe;
			o_slow <= next_slow;
			o_pull_up <= next_pu;
			o_pull_down <= next_pd;
		end
	end
endmodule // pcg_pin_drive

// ==== tb/pcg_gpio_bank_props.sv ====
// Checker for the pin bank's command and reply strobes.
// Assumes it is bound to the bank and sees only its ports.
`timescale 1ns/1ps
module pcg_gpio_bank_props
(
	// Clock, reset and command.
	input wire I_SYS_CLK,
	input wire I_RESET_N,
	input wire I_CMD_VALID,
	input wire [7:0] I_CMD_TYPE,
	input wire [1:0] I_CMD_LEN,
	input wire [7:0] I_CMD_D0,
	input wire [7:0] I_CMD_D1,
	input wire [7:0] I_CMD_D2,
	input wire I_BOOT_LOAD,
	// Reply.
	input wire O_RSP_VALID,
	input wire [7:0] O_RSP_TYPE,
	input wire [2:0] O_RSP_LEN,
	input wire [7:0] O_RSP_D0,
	input wire O_CMD_REJECT
);
	// Decoded kinds of command; a boot load takes precedence.
	wire cfg = I_CMD_VALID && !I_BOOT_LOAD && I_CMD_TYPE == 8'h22;
	wire qry = I_CMD_VALID && !I_BOOT_LOAD && I_CMD_TYPE == 8'h23 && I_CMD_LEN == 2'h1;
	wire len_ok = I_CMD_LEN == 2'h2 || (I_CMD_LEN == 2'h3 && I_CMD_D2 <= 8'h0F);
	wire cfg_ok = cfg && len_ok && I_CMD_D0 < 8'h05 && I_CMD_D1 <= 8'h64;
	default clocking cb @(posedge I_SYS_CLK);
	endclocking
	default disable iff (!I_RESET_N);
	a_cfg_reply: assert property (cfg_ok |=> O_RSP_VALID && O_RSP_TYPE == 8'h62 && O_RSP_LEN == 3'h0)
		else $error("configure reply wrong");
	a_bad_index: assert property (cfg && I_CMD_D0 >= 8'h05 |=> O_CMD_REJECT && !O_RSP_VALID)
		else $error("bad index accepted");
	a_bad_duty: assert property (cfg && I_CMD_D1 > 8'h64 |=> O_CMD_REJECT)
		else $error("bad duty accepted");
	a_bad_mode: assert property (cfg && I_CMD_LEN == 2'h3 && I_CMD_D2 > 8'h0F |=> O_CMD_REJECT)
		else $error("bad mode accepted");
	a_query_reply: assert property (qry && I_CMD_D0 < 8'h05 |=> O_RSP_VALID && O_RSP_TYPE == 8'h63 && O_RSP_D0 == $past(I_CMD_D0))
		else $error("query reply wrong");
	a_reply_cause: assert property (O_RSP_VALID |-> $past(I_CMD_VALID))
		else $error("reply without command");
	a_reply_holds: assert property (!O_RSP_VALID |-> $stable(O_RSP_TYPE) && $stable(O_RSP_LEN))
		else $error("reply data moved");
	a_reject_alone: assert property (O_CMD_REJECT |-> !O_RSP_VALID && $past(I_CMD_VALID))
		else $error("reject with reply");
endmodule // pcg_gpio_bank_props
bind pcg_gpio_bank pcg_gpio_bank_props props (.*);

// ==== tb/pcg_gpio_bank_tb.sv ====
// Bench for the pin bank: configure, reject, drive modes, PWM, sampling, boot load.
// Assumes short PWM and sample counts set as parameters below.
`timescale 1ns/1ps
module pcg_gpio_bank_tb;
	localparam STEP = 2;
	localparam SAMP = 20;
	localparam [7:0] OE_HI = 8'h33;
	localparam [7:0] OE_LO = 8'hAA;
	localparam [7:0] SLOW = 8'hB0;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [4:0] def_out = 5'h00;
	reg [4:0] def_oe = 5'h00;
	reg [4:0] closed = 5'h00;
	reg boot_load = 1'b0;
	reg [39:0] boot_duty = 40'h0102030405;
	reg [19:0] boot_mode = 20'h2391B;
	wire cv;
	wire [7:0] ct;
	wire [1:0] cl;
	wire [7:0] c0, c1, c2, r_type, r0, r1, r2, r3;
	wire rv, rej;
	wire [2:0] r_len;
	wire [39:0] cfg_duty;
	wire [19:0] cfg_mode;
	wire [4:0] pin_in, pin_out, pin_oe, pin_pu, pin_pd, pin_slow, sampled;
	integer mismatches = 0;
	integer tests_run = 0;
	integer m, n;
	always #2.5 clk = ~clk;
	pcg_host_model host (.i_clk(clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_pin_pu(pin_pu), .i_pin_pd(pin_pd),
		.i_closed(closed), .o_valid(cv), .o_type(ct), .o_len(cl), .o_d0(c0), .o_d1(c1), .o_d2(c2), .o_pin(pin_in));
	pcg_gpio_bank #(.PWM_STEP_CYC(STEP), .SAMPLE_CYC(SAMP)) dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_CMD_VALID(cv),
		.I_CMD_TYPE(ct), .I_CMD_LEN(cl), .I_CMD_D0(c0), .I_CMD_D1(c1), .I_CMD_D2(c2), .O_RSP_VALID(rv),
		.O_RSP_TYPE(r_type), .O_RSP_LEN(r_len), .O_RSP_D0(r0), .O_RSP_D1(r1), .O_RSP_D2(r2), .O_RSP_D3(r3),
		.O_CMD_REJECT(rej), .I_BOOT_LOAD(boot_load), .I_BOOT_DUTY(boot_duty), .I_BOOT_MODE(boot_mode),
		.O_CFG_DUTY(cfg_duty), .O_CFG_MODE(cfg_mode), .I_DEF_OUT(def_out), .I_DEF_OE(def_oe), .O_SAMPLED(sampled),
		.I_PIN(pin_in), .O_PIN(pin_out), .O_PIN_OE(pin_oe), .O_PIN_SLOW(pin_slow), .O_PIN_PU(pin_pu),
		.O_PIN_PD(pin_pd));
	// Compares one value and counts it.
	task check(input [39:0] seen, input [39:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp)
			begin
				mismatches = mismatches + 1;
				$display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
			end
		end
	endtask
	// Waits k edges, then steps off the edge so outputs have settled.
	task pause(input integer k);
		begin
			repeat (k) @(posedge clk);
			#1;
		end
	endtask
	task report_and_stop;
		begin
			$display("checks %0d, mismatches %0d", tests_run, mismatches);
			if (mismatches == 0 && tests_run > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask
	// Accepted configure, then a two-byte one that keeps the mode.
	task t_config;
		begin
			pause(1);
			check(cfg_mode, 20'h22232);
			host.send(8'h22, 2'h3, 8'h01, 8'h32, 8'h09);
			check({rv, r_type, r_len}, {1'b1, 8'h62, 3'h0});
			host.send(8'h22, 2'h2, 8'h01, 8'h64, 8'h0F);
			pause(1);
			check({cfg_duty, cfg_mode}, {40'h0000006400, 20'h22292});
			$display("t_config done");
		end
	endtask
	// Out-of-range index, duty and mode change nothing.
	task t_reject;
		begin
			host.send(8'h22, 2'h3, 8'h05, 8'h00, 8'h02);
			check({rej, rv}, 2'b10);
			host.send(8'h22, 2'h2, 8'h00, 8'h65, 8'h00);
			check({rej, rv}, 2'b10);
			host.send(8'h22, 2'h3, 8'h00, 8'h00, 8'h10);
			check({rej, rv}, 2'b10);
			pause(1);
			check({cfg_duty, cfg_mode}, {40'h0000006400, 20'h22292});
			$display("t_reject done");
		end
	endtask
	// Every drive mode except reserved 110 at both levels, then the default function.
	task t_drive;
		begin
			for (m = 0; m < 8; m = m + 1)
			begin
				if (m != 6)
				begin
					host.send(8'h22, 2'h3, 8'h00, 8'h64, 8'h08 | m);
					pause(4);
					check({pin_oe[0], pin_pu[0], pin_slow[0]}, {OE_HI[m], m == 3, SLOW[m]});
					host.send(8'h22, 2'h2, 8'h00, 8'h00, 8'h00);
					pause(4);
					check({pin_oe[0], pin_pd[0], pin_slow[0]}, {OE_LO[m], m == 0, SLOW[m]});
				end
			end
			def_oe = 5'h01;
			host.send(8'h22, 2'h3, 8'h00, 8'h64, 8'h01);
			pause(4);
			check({pin_oe[0], pin_out[0]}, 2'b10);
			def_out = 5'h01;
			pause(4);
			check({pin_oe[0], pin_out[0]}, 2'b11);
			def_oe = 5'h00;
			$display("t_drive done");
		end
	endtask
	// Half duty is high for exactly half of one full period.
	task t_pwm;
		begin
			host.send(8'h22, 2'h3, 8'h00, 8'h32, 8'h09);
			pause(4);
			n = 0;
			repeat (100 * STEP)
			begin
				@(posedge clk);
				#1;
				n = n + pin_out[0];
			end
			check(n, 50 * STEP);
			$display("t_pwm done");
		end
	endtask
	// Pull-up with a switch: level and edge flags, cleared by each query.
	task t_sample;
		begin
			host.send(8'h22, 2'h3, 8'h00, 8'h64, 8'h0B);
			pause(3 * SAMP);
			host.send(8'h23, 2'h1, 8'h00, 8'h00, 8'h00);
			closed = 5'h01;
			pause(3 * SAMP);
			host.send(8'h23, 2'h1, 8'h00, 8'h00, 8'h00);
			check({r_len, r0, r1, r2, r3}, {3'h4, 8'h00, 24'h02640B});
			host.send(8'h23, 2'h1, 8'h00, 8'h00, 8'h00);
			check(r1, 8'h00);
			closed = 5'h00;
			pause(3 * SAMP);
			host.send(8'h23, 2'h1, 8'h00, 8'h00, 8'h00);
			check(r1, 8'h05);
			check(sampled[0], 1'b1);
			check(cfg_mode[19:8], 12'h222);
			$display("t_sample done");
		end
	endtask
	// Saved state loads into every pin.
	task t_boot;
		begin
			@(posedge clk);
			#1;
			boot_load = 1'b1;
			@(posedge clk);
			#1;
			boot_load = 1'b0;
			pause(2);
			check({cfg_duty, cfg_mode}, {boot_duty, boot_mode});
			$display("t_boot done");
		end
	endtask
	initial
	begin
		pause(16);
		rst_n = 1'b1;
		t_config;
		t_reject;
		t_drive;
		t_pwm;
		t_sample;
		t_boot;
		report_and_stop;
	end
	initial
	begin
		#50000;
		mismatches = mismatches + 1;
		report_and_stop;
	end
endmodule // pcg_gpio_bank_tb

// ==== tb/pcg_host_model.sv ====
// Host model: sends command strobes and models each pad with a switch to ground.
// Assumes the bench calls send from one process only.
`timescale 1ns/1ps
module pcg_host_model
(
	// Clock and pad controls.
	input wire i_clk,
	input wire [4:0] i_pin_out,
	input wire [4:0] i_pin_oe,
	input wire [4:0] i_pin_pu,
	input wire [4:0] i_pin_pd,
	input wire [4:0] i_closed,
	// Command.
	output reg o_valid,
	output reg [7:0] o_type,
	output reg [1:0] o_len,
	output reg [7:0] o_d0,
	output reg [7:0] o_d1,
	output reg [7:0] o_d2,
	// Pad level.
	output wire [4:0] o_pin
);
	reg tog;
	// A floating pad wanders each cycle so no stale level reads as valid.
	always @(posedge i_clk)
		tog <= ~tog;
	assign o_pin = (i_pin_oe & i_pin_out) | (~i_pin_oe & ~i_closed & (i_pin_pu | (~i_pin_pd & {5{tog}})));
	initial
	begin
		tog = 1'b0;
		o_valid = 1'b0;
		{o_type, o_len, o_d0, o_d1, o_d2} = 34'h0;
	end
	// One-cycle command strobe with its payload.
	task send(input [7:0] t, input [1:0] l, input [7:0] a, input [7:0] b, input [7:0] c);
		begin
			@(posedge i_clk);
			#1;
			{o_valid, o_type, o_len, o_d0, o_d1, o_d2} = {1'b1, t, l, a, b, c};
			@(posedge i_clk);
			#1;
			o_valid = 1'b0;
			{o_d0, o_d1, o_d2} = ~{o_d0, o_d1, o_d2};
		end
	endtask
endmodule // pcg_host_model
